// ### timer2_reload_compare_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
// ==========================================================
// Bench: bus tasks, pin model, scenario sequence
module timer2_reload_compare_unit_tb;
   logic clk, rst_n, cyc, stb, we, drop, ack, ext_pin, irq_t;
   logic [7:0] adr;
   logic [3:0] sel, pin_in, pin_out, irq_c;
   logic [31:0] wdat, rdat, dat_o;
   int bad_count = 0;
   int n_checks = 0;
   trc_unit dut_u (.CLK_SYS(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .EXT_RELOAD_PIN(ext_pin), .CMP_PIN_IN(pin_in),
      .CMP_PIN_OUT(pin_out), .IRQ_TIMER(irq_t), .IRQ_CMP(irq_c));
   trc_pin_model pins_u (.clk(clk), .pin_out(pin_out), .drop(drop), .ext_pin(ext_pin),
      .pin_in(pin_in));
   // ==========================================================
   // Classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 20) bad_count++;
      // Let the ack-edge updates settle before the caller looks at pins
      @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      wb(1'b1, a, v);
   endtask
   task automatic rd(input logic [7:0] a);
      wb(1'b0, a, 32'h0);
   endtask
   // Values read here are those of the cycle before the edge
   task automatic wait_pin(input int b, input logic v);
      int k;
      k = 0;
      while (pin_out[b] !== v && k < 100) begin
         @(posedge clk);
         k++;
      end
      `CHK(pin_out[b], v)
   endtask
   // One commanded falling edge, then time for sync and reload
   task automatic edge_drop();
      @(posedge clk);
      drop <= 1'b1;
      @(posedge clk);
      drop <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
   task automatic conclude();
      if (bad_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // Clock, watchdog and scenarios
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Scenarios need well under a thousand cycles
   initial begin
      #200000;
      bad_count++;
      conclude();
   end
   initial begin
      {rst_n, cyc, stb, we, drop} = 5'h00;
      adr = 8'h00;
      sel = 4'hf;
      wdat = 32'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      `CHK(pin_out, trc_pkg::TRC_PORT_RESET)
      rd(8'h28);
      `CHK(rdat, 32'h0)
      wr(trc_pkg::TRC_OFS_PORT, 32'h5);
      `CHK(pin_out, 4'h5)
      // Pin readback passes two sync stages first
      repeat (2) @(posedge clk);
      rd(trc_pkg::TRC_OFS_PORT);
      `CHK(rdat[3:0], 4'h5)
      // Overflow reload: wrap lands on the reload value
      wr(trc_pkg::TRC_OFS_RELOAD, 32'h1234);
      wr(trc_pkg::TRC_OFS_COUNT, 32'hfffe);
      wr(trc_pkg::TRC_OFS_CTRL, 32'h62);
      wr(trc_pkg::TRC_OFS_CTRL, 32'h22);
      rd(trc_pkg::TRC_OFS_COUNT);
      `CHK(rdat[15:8], 8'h12)
      rd(trc_pkg::TRC_OFS_STATUS);
      `CHK(rdat[0], 1'b1)
      `CHK(irq_t, 1'b1)
      wr(trc_pkg::TRC_OFS_STATUS, 32'h1);
      rd(trc_pkg::TRC_OFS_STATUS);
      `CHK(rdat[0], 1'b0)
      `CHK(irq_t, 1'b0)
      // Pin reload with and without the flag enable, then no reload
      wr(trc_pkg::TRC_OFS_CTRL, 32'h33);
      wr(trc_pkg::TRC_OFS_COUNT, 32'h0);
      wr(trc_pkg::TRC_OFS_RELOAD, 32'habcd);
      edge_drop();
      rd(trc_pkg::TRC_OFS_COUNT);
      `CHK(rdat[15:0], 16'habcd)
      rd(trc_pkg::TRC_OFS_STATUS);
      `CHK(rdat[1], 1'b1)
      `CHK(irq_t, 1'b1)
      wr(trc_pkg::TRC_OFS_STATUS, 32'h2);
      rd(trc_pkg::TRC_OFS_STATUS);
      `CHK(rdat[1], 1'b0)
      wr(trc_pkg::TRC_OFS_CTRL, 32'h23);
      wr(trc_pkg::TRC_OFS_COUNT, 32'h0);
      edge_drop();
      rd(trc_pkg::TRC_OFS_COUNT);
      `CHK(rdat[15:0], 16'habcd)
      rd(trc_pkg::TRC_OFS_STATUS);
      `CHK(rdat[1], 1'b0)
      wr(trc_pkg::TRC_OFS_CTRL, 32'h20);
      wr(trc_pkg::TRC_OFS_COUNT, 32'h0);
      edge_drop();
      rd(trc_pkg::TRC_OFS_COUNT);
      `CHK(rdat[15:0], 16'h0)
      // Compare mode 0 on pin one: writes ignored, high on match, low on wrap
      wr(trc_pkg::TRC_OFS_PORT, 32'h0);
      // Compare value set first, so enabling does not match the count
      wr(trc_pkg::TRC_OFS_CMP1, 32'h8);
      wr(trc_pkg::TRC_OFS_COMPARE_CAPTURE_ENABLE_REG, 32'h08);
      wr(trc_pkg::TRC_OFS_PORT, 32'hf);
      `CHK(pin_out[1], 1'b0)
      wr(trc_pkg::TRC_OFS_RELOAD, 32'h0);
      wr(trc_pkg::TRC_OFS_STATUS, 32'h3c);
      wr(trc_pkg::TRC_OFS_COUNT, 32'hfff8);
      wr(trc_pkg::TRC_OFS_CTRL, 32'h42);
      wait_pin(1, 1'b1);
      rd(trc_pkg::TRC_OFS_STATUS);
      `CHK(rdat[3], 1'b1)
      wr(trc_pkg::TRC_OFS_COUNT, 32'hfff0);
      wait_pin(1, 1'b0);
      // Match at the top count leaves a single-cycle spike
      wr(trc_pkg::TRC_OFS_CMP1, 32'hffff);
      wr(trc_pkg::TRC_OFS_COUNT, 32'hfff0);
      wait_pin(1, 1'b1);
      @(posedge clk);
      `CHK(pin_out[1], 1'b0)
      // Compare mode 1 on pin two: shadow, copy on match, transparency
      wr(trc_pkg::TRC_OFS_CTRL, 32'h04);
      wr(trc_pkg::TRC_OFS_COMPARE_CAPTURE_ENABLE_REG, 32'h20);
      wr(trc_pkg::TRC_OFS_CMP2, 32'h10);
      wr(trc_pkg::TRC_OFS_COUNT, 32'h0);
      wr(trc_pkg::TRC_OFS_PORT, 32'h0);
      `CHK(pin_out, 4'h4)
      rd(trc_pkg::TRC_OFS_SHADOW);
      `CHK(rdat[2], 1'b0)
      rd(trc_pkg::TRC_OFS_PORT);
      `CHK(rdat[3:0], 4'h4)
      wr(trc_pkg::TRC_OFS_CTRL, 32'h44);
      wait_pin(2, 1'b0);
      wr(trc_pkg::TRC_OFS_CTRL, 32'h04);
      wr(trc_pkg::TRC_OFS_COUNT, 32'h10);
      wr(trc_pkg::TRC_OFS_PORT, 32'h4);
      `CHK(pin_out[2], 1'b1)
      // Register zero flag follows the edge select bit
      wr(trc_pkg::TRC_OFS_COMPARE_CAPTURE_ENABLE_REG, 32'h02);
      wr(trc_pkg::TRC_OFS_STATUS, 32'h3c);
      wr(trc_pkg::TRC_OFS_RELOAD, 32'h50);
      wr(trc_pkg::TRC_OFS_CTRL, 32'h08);
      wr(trc_pkg::TRC_OFS_COUNT, 32'h50);
      rd(trc_pkg::TRC_OFS_STATUS);
      `CHK(rdat[2], 1'b1)
      wr(trc_pkg::TRC_OFS_STATUS, 32'h4);
      wr(trc_pkg::TRC_OFS_CTRL, 32'h00);
      rd(trc_pkg::TRC_OFS_STATUS);
      `CHK(rdat[2], 1'b0)
      wr(trc_pkg::TRC_OFS_COUNT, 32'h51);
      rd(trc_pkg::TRC_OFS_STATUS);
      `CHK(rdat[2], 1'b1)
      `CHK(irq_c[0], 1'b1)
      conclude();
   end
endmodule
`default_nettype wire

// ### trc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Loads on the compare pins and the reload edge source
module trc_pin_model (
   input wire logic clk,
   input wire logic [3:0] pin_out,
   input wire logic drop,
   output logic ext_pin,
   output logic [3:0] pin_in
);
   int low_left = 0;
   // Push-pull outputs into light loads, so each pin shows its latch
   assign pin_in = pin_out;
   // Held low six cycles, well past one sample period
   always @(posedge clk) begin
      if (drop) begin
         low_left <= 6;
      end else if (low_left > 0) begin
         low_left <= low_left - 1;
      end
   end
   // Idle level high, so only a commanded drop makes a falling edge
   assign ext_pin = (low_left == 0);
endmodule
`default_nettype wire

// ### trc_pkg.sv
package trc_pkg;
   // ==========================================================
   // Register map (byte addresses, one word each)
   localparam logic [7:0] TRC_OFS_CTRL = 8'h00;
   localparam logic [7:0] TRC_OFS_STATUS = 8'h04;
   localparam logic [7:0] TRC_OFS_COUNT = 8'h08;
   localparam logic [7:0] TRC_OFS_RELOAD = 8'h0c;
   localparam logic [7:0] TRC_OFS_CMP1 = 8'h10;
   localparam logic [7:0] TRC_OFS_CMP2 = 8'h14;
   localparam logic [7:0] TRC_OFS_CMP3 = 8'h18;
   localparam logic [7:0] TRC_OFS_COMPARE_CAPTURE_ENABLE_REG = 8'h1c;
   localparam logic [7:0] TRC_OFS_PORT = 8'h20;
   localparam logic [7:0] TRC_OFS_SHADOW = 8'h24;

   // ==========================================================
   // Control register fields
   localparam int TRC_CTRL_RMODE_LO = 0;
   localparam int TRC_CTRL_RMODE_HI = 1;
   localparam int TRC_CTRL_CMODE = 2;
   localparam int TRC_CTRL_EDGE_SEL = 3;
   localparam int TRC_CTRL_EXT_FLAG_EN = 4;
   localparam int TRC_CTRL_TIMER_IE = 5;
   localparam int TRC_CTRL_RUN = 6;
   localparam int TRC_CTRL_WIDTH = 7;
   localparam logic [6:0] TRC_CTRL_RESET = 7'h00;

   // Status register fields (write one to clear)
   localparam int TRC_ST_OVF = 0;
   localparam int TRC_ST_EXT = 1;
   localparam int TRC_ST_CMP0 = 2;

   // Reload mode selections {hi, lo}
   localparam logic [1:0] TRC_RMODE_AUTO = 2'h2;
   localparam logic [1:0] TRC_RMODE_EXT = 2'h3;

   // Compare/capture enable field code for compare
   localparam logic [1:0] TRC_COMPARE_CAPTURE_ENABLE_REG_COMPARE = 2'h2;

   // ==========================================================
   // Reset values and counter limits
   localparam logic [15:0] TRC_COUNT_MAX = 16'hffff;
   localparam logic [15:0] TRC_REG16_RESET = 16'h0000;
   localparam logic [7:0] TRC_COMPARE_CAPTURE_ENABLE_REG_RESET = 8'h00;
   localparam logic [3:0] TRC_PORT_RESET = 4'hf;
endpackage

// ### trc_unit.sv
`timescale 1ns/1ps
`default_nettype none
module trc_unit (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic EXT_RELOAD_PIN,
   input wire logic [3:0] CMP_PIN_IN,
   output logic [3:0] CMP_PIN_OUT,
   output logic IRQ_TIMER,
   output logic [3:0] IRQ_CMP
);
   // ==========================================================
   // Helpers
   function automatic logic cmp_enabled(input logic [7:0] compare_capture_enable_reg, input int idx);
      cmp_enabled = (compare_capture_enable_reg[2*idx +: 2] == trc_pkg::TRC_COMPARE_CAPTURE_ENABLE_REG_COMPARE);
   endfunction

   logic [6:0] ctrl_q;
   logic [3:0] st_cmp_q;
   logic st_ovf_q, st_ext_q;
   logic [15:0] count_q, count_d;
   logic [15:0] cmp_q [4];
   logic [7:0] compare_capture_enable_reg_q;
   logic [3:0] out_q, shadow_q, hit_q, hit_d;
   logic ack_q, irq_t_q;
   logic [3:0] irq_c_q;
   logic [31:0] rdat_q;
   logic [1:0] rmode;
   logic cmode;
   logic wr_en, wr_ctrl, wr_st, wr_count, wr_port, ovf_ev;
   logic rl_s1, rl_s2, rl_prev, edge_q;
   logic [3:0] pin_s1, pin_s2;
   logic [3:0] rise, fall, cmp_ev;

   assign rmode = {ctrl_q[trc_pkg::TRC_CTRL_RMODE_HI], ctrl_q[trc_pkg::TRC_CTRL_RMODE_LO]};
   assign cmode = ctrl_q[trc_pkg::TRC_CTRL_CMODE];

   // ==========================================================
   // Wishbone slave: ack one cycle after strobe, write at ack edge
   assign wr_en = WB_CYC_I & WB_STB_I & WB_WE_I & ack_q & WB_SEL_I[0];
   assign wr_ctrl = wr_en & (WB_ADR_I == trc_pkg::TRC_OFS_CTRL);
   assign wr_st = wr_en & (WB_ADR_I == trc_pkg::TRC_OFS_STATUS);
   assign wr_count = wr_en & (WB_ADR_I == trc_pkg::TRC_OFS_COUNT);
   assign wr_port = wr_en & (WB_ADR_I == trc_pkg::TRC_OFS_PORT);

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= WB_CYC_I & WB_STB_I & ~ack_q;
      end
   end

   // Read data captured in the strobe cycle; unmapped reads return zero
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rdat_q <= 32'h0000_0000;
      end else if (WB_CYC_I & WB_STB_I & ~ack_q) begin
         rdat_q <= 32'h0000_0000;
         if (WB_ADR_I == trc_pkg::TRC_OFS_CTRL) begin
            rdat_q[6:0] <= ctrl_q;
         end else if (WB_ADR_I == trc_pkg::TRC_OFS_STATUS) begin
            rdat_q[5:0] <= {st_cmp_q, st_ext_q, st_ovf_q};
         end else if (WB_ADR_I == trc_pkg::TRC_OFS_COUNT) begin
            rdat_q[15:0] <= count_q;
         end else if (WB_ADR_I == trc_pkg::TRC_OFS_RELOAD) begin
            rdat_q[15:0] <= cmp_q[0];
         end else if (WB_ADR_I == trc_pkg::TRC_OFS_CMP1) begin
            rdat_q[15:0] <= cmp_q[1];
         end else if (WB_ADR_I == trc_pkg::TRC_OFS_CMP2) begin
            rdat_q[15:0] <= cmp_q[2];
         end else if (WB_ADR_I == trc_pkg::TRC_OFS_CMP3) begin
            rdat_q[15:0] <= cmp_q[3];
         end else if (WB_ADR_I == trc_pkg::TRC_OFS_COMPARE_CAPTURE_ENABLE_REG) begin
            rdat_q[7:0] <= compare_capture_enable_reg_q;
         end else if (WB_ADR_I == trc_pkg::TRC_OFS_PORT) begin
            rdat_q[3:0] <= pin_s2;
         end else if (WB_ADR_I == trc_pkg::TRC_OFS_SHADOW) begin
            rdat_q[3:0] <= shadow_q;
         end
      end
   end

   // Configuration registers; 16-bit values need both low byte lanes
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_q <= trc_pkg::TRC_CTRL_RESET;
         compare_capture_enable_reg_q <= trc_pkg::TRC_COMPARE_CAPTURE_ENABLE_REG_RESET;
         for (int i = 0; i < 4; i++) begin
            cmp_q[i] <= trc_pkg::TRC_REG16_RESET;
         end
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= WB_DAT_I[6:0];
         end
         if (wr_en & (WB_ADR_I == trc_pkg::TRC_OFS_COMPARE_CAPTURE_ENABLE_REG)) begin
            compare_capture_enable_reg_q <= WB_DAT_I[7:0];
         end
         if (wr_en & WB_SEL_I[1]) begin
            if (WB_ADR_I == trc_pkg::TRC_OFS_RELOAD) begin
               cmp_q[0] <= WB_DAT_I[15:0];
            end else if (WB_ADR_I == trc_pkg::TRC_OFS_CMP1) begin
               cmp_q[1] <= WB_DAT_I[15:0];
            end else if (WB_ADR_I == trc_pkg::TRC_OFS_CMP2) begin
               cmp_q[2] <= WB_DAT_I[15:0];
            end else if (WB_ADR_I == trc_pkg::TRC_OFS_CMP3) begin
               cmp_q[3] <= WB_DAT_I[15:0];
            end
         end
      end
   end

   // ==========================================================
   // Reload pin: two-stage sync, then one more sample for the edge
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rl_s1 <= 1'b1;
         rl_s2 <= 1'b1;
         rl_prev <= 1'b1;
         edge_q <= 1'b0;
         pin_s1 <= 4'h0;
         pin_s2 <= 4'h0;
      end else begin
         rl_s1 <= EXT_RELOAD_PIN;
         rl_s2 <= rl_s1;
         rl_prev <= rl_s2;
         edge_q <= rl_prev & ~rl_s2;
         pin_s1 <= CMP_PIN_IN;
         pin_s2 <= pin_s1;
      end
   end

   // ==========================================================
   // Next count: software write, then pin reload, then counting
   always_comb begin
      ovf_ev = ctrl_q[trc_pkg::TRC_CTRL_RUN] & (count_q == trc_pkg::TRC_COUNT_MAX);
      count_d = count_q;
      if (wr_count & WB_SEL_I[1]) begin
         count_d = WB_DAT_I[15:0];
      end else if (edge_q & (rmode == trc_pkg::TRC_RMODE_EXT)) begin
         count_d = cmp_q[0];
      end else if (ovf_ev & (rmode == trc_pkg::TRC_RMODE_AUTO)) begin
         count_d = cmp_q[0]; // Reload overwrites the zero count
      end else if (ctrl_q[trc_pkg::TRC_CTRL_RUN]) begin
         count_d = 16'(count_q + 16'h0001);
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         count_q <= trc_pkg::TRC_REG16_RESET;
      end else begin
         count_q <= count_d;
      end
   end

   // ==========================================================
   // Compare signals track the next count so pin and count move together
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         hit_d[i] = cmp_enabled(compare_capture_enable_reg_q, i) & (count_d == cmp_q[i]);
      end
      rise = hit_d & ~hit_q;
      fall = ~hit_d & hit_q;
      cmp_ev = {rise[3:1], ctrl_q[trc_pkg::TRC_CTRL_EDGE_SEL] ? rise[0] : fall[0]};
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         hit_q <= 4'h0;
      end else begin
         hit_q <= hit_d;
      end
   end

   // ==========================================================
   // Sticky flags; a set in the same cycle as a clear wins
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         st_ovf_q <= 1'b0;
         st_ext_q <= 1'b0;
         st_cmp_q <= 4'h0;
      end else begin
         st_ovf_q <= ovf_ev | (st_ovf_q & ~(wr_st & WB_DAT_I[trc_pkg::TRC_ST_OVF]));
         st_ext_q <= (edge_q & ctrl_q[trc_pkg::TRC_CTRL_EXT_FLAG_EN])
                     | (st_ext_q & ~(wr_st & WB_DAT_I[trc_pkg::TRC_ST_EXT]));
         st_cmp_q <= cmp_ev | (st_cmp_q & ~({4{wr_st}} & WB_DAT_I[trc_pkg::TRC_ST_CMP0 +: 4]));
      end
   end

   // Request lines follow the flags; overflow and pin reload share one
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         irq_t_q <= 1'b0;
         irq_c_q <= 4'h0;
      end else begin
         irq_t_q <= ctrl_q[trc_pkg::TRC_CTRL_TIMER_IE] & (st_ovf_q | st_ext_q);
         irq_c_q <= st_cmp_q;
      end
   end

   // ==========================================================
   // Port latches per pin: disabled, mode 0 or mode 1
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         out_q <= trc_pkg::TRC_PORT_RESET;
         shadow_q <= trc_pkg::TRC_PORT_RESET;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (!cmp_enabled(compare_capture_enable_reg_q, i)) begin
               if (wr_port) begin
                  out_q[i] <= WB_DAT_I[i];
                  shadow_q[i] <= WB_DAT_I[i];
               end
            end else if (!cmode) begin
               // Match wins over overflow: the residual spike at the extremes
               if (hit_d[i]) begin
                  out_q[i] <= 1'b1;
               end else if (ovf_ev) begin
                  out_q[i] <= 1'b0;
               end // Writes dropped here
            end else begin
               if (wr_port) begin
                  shadow_q[i] <= WB_DAT_I[i];
               end
               // Transparent while active, so a late ISR write reaches the pin
               if (hit_d[i]) begin
                  out_q[i] <= wr_port ? WB_DAT_I[i] : shadow_q[i];
               end
            end
         end
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = rdat_q;
   assign CMP_PIN_OUT = out_q;
   assign IRQ_TIMER = irq_t_q;
   assign IRQ_CMP = irq_c_q;

   // ==========================================================
   // Assertions
   a_ack_single: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      ack_q |=> !ack_q) else $error("ack held two cycles");

   a_ovf_flag_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      ovf_ev |=> st_ovf_q) else $error("overflow flag not set on wrap");

   a_auto_reload: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (ovf_ev && rmode == trc_pkg::TRC_RMODE_AUTO && !wr_count && !edge_q)
      |=> count_q == $past(cmp_q[0])) else $error("auto reload missed");

   a_ext_reload: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      ($fell(rl_s2) && rmode == trc_pkg::TRC_RMODE_EXT)
      ##1 (rmode == trc_pkg::TRC_RMODE_EXT && !wr_count) |=> count_q == $past(cmp_q[0]))
      else $error("pin reload not in following cycle");

   a_ext_flag_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (edge_q && !ctrl_q[trc_pkg::TRC_CTRL_EXT_FLAG_EN] && !st_ext_q) |=> !st_ext_q)
      else $error("external flag set while disabled");

   a_hit_tracks: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      hit_q[1] == (cmp_enabled(compare_capture_enable_reg_q, 1) && count_q == cmp_q[1] && $stable(cmp_q[1])
      && $stable(compare_capture_enable_reg_q)) || !($stable(cmp_q[1]) && $stable(compare_capture_enable_reg_q)))
      else $error("compare signal does not track match");

   a_mode0_high: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (hit_d[1] && !cmode && cmp_enabled(compare_capture_enable_reg_q, 1)) |=> out_q[1])
      else $error("mode 0 pin not high on match");

   a_mode0_nowrite: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (wr_port && !cmode && cmp_enabled(compare_capture_enable_reg_q, 1) && !hit_d[1] && !ovf_ev)
      |=> $stable(out_q[1])) else $error("mode 0 pin took a write");

   a_cmp1_rise_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      rise[1] |=> st_cmp_q[1] ##1 irq_c_q[1]) else $error("compare request missing");
endmodule
`default_nettype wire
